// file: src/ips_pkg.sv
`default_nettype none
package ips_pkg;
   // fixed upper address bits and variant prefixes
   localparam logic [3:0] ADDR_FIXED      = 4'h5;
   localparam logic [1:0] VARIANT_ONE_PIN = 2'h0;
   localparam logic [1:0] VARIANT_TWO_PIN = 2'h1;
   localparam logic [1:0] VARIANT_THREE   = 2'h2;
   localparam logic [6:0] GENERAL_CALL    = 7'h00;
   localparam logic [4:0] HS_CODE_TOP     = 5'h01;   // 0000 1xxx
   localparam int         GCA_BIT_POS     = 8;       // accept bit within terminal control word
   localparam logic [3:0] BIT_COUNT_ACK   = 4'h8;
   localparam logic [3:0] BIT_COUNT_RST   = 4'h0;
   localparam int         CLK_MHZ         = 125;
   localparam int         HS_RATE_KHZ     = 3400;
   // clk cycles per shortest hs half period, rounded down
   localparam int         HS_HALF_CYC     = (CLK_MHZ * 1000) / (2 * HS_RATE_KHZ);
   localparam int         BUF_DEPTH       = 2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK  = 3'b010,
      ST_CMD  = 3'b011,
      ST_DATA = 3'b100,
      ST_READ = 3'b101,
      ST_WAIT = 3'b110
   } ips_state_e;

   // byte handed to the command layer
   typedef struct packed {
      logic       first;    // command byte after address
      logic       hv;       // high-voltage command marker
      logic [7:0] data;
   } ips_word_s;
endpackage : ips_pkg
`default_nettype wire

// file: src/ips_slave.sv
`default_nettype none
module ips_slave
   import ips_pkg::*;
#(
   parameter logic [1:0] VARIANT = 2'h2                // address pin count selection
)(
   input  wire logic        clk,                      // 125 MHz system clock
   input  wire logic        rst,                      // synchronous reset, high
   input  wire logic        scl_i,                    // serial clock pin
   input  wire logic        sda_i,                    // serial data pin level
   output logic             sda_o,                    // data drive value, always low
   output logic             sda_oe,                   // high while pulling data low
   input  wire logic        addr_pin_zero,            // address pin zero, hv shared
   input  wire logic        addr_pin_one,             // address pin one
   input  wire logic        addr_pin_two,             // address pin two
   input  wire logic        high_voltage_cmd_input,   // high-voltage level detected
   input  wire logic [8:0]  tcon_word,                // terminal control word
   input  wire logic        cmd_valid_in,             // location/op combination legal
   input  wire logic [7:0]  rd_data,                  // byte to send on reads
   output logic             word_valid,               // buffered byte ready
   input  wire logic        word_ready,               // command layer takes byte
   output ips_word_s        word_out,                 // buffered byte
   output logic             frame_abort,              // pulse: stop/start/collision
   output logic             hs_mode,                  // high-speed mode active
   output logic             busy                      // any address byte or acked transfer underway; low in wait
);
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic       scl_s;
   logic       sda_s;
   logic       scl_prev;
   logic       sda_prev;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       a0_latched;
   logic       a0_taken;
   logic [6:0] own_addr;
   ips_state_e state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic       ack_drive;
   logic       tx_drive;
   logic       is_read;
   logic       first_byte;
   logic       hv_seen;
   logic       rs_pending;
   logic       collision;
   logic       buf_in_valid;
   logic       buf_in_ready;
   ips_word_s  buf_in;
   ips_word_s  buf_mem [BUF_DEPTH];
   logic       wr_ptr;
   logic       rd_ptr;
   logic [1:0] count;

   // three-stage synchronisers; stage two and three must agree
   always_ff @(posedge clk) begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
   end

   // filtered levels only change once two stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         scl_s    <= 1'b1;
         sda_s    <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         if (scl_sync[1] == scl_sync[2]) scl_s <= scl_sync[2];
         if (sda_sync[1] == sda_sync[2]) sda_s <= sda_sync[2];
         scl_prev <= scl_s;
         sda_prev <= sda_s;
      end
   end

   assign scl_rise  = scl_s & ~scl_prev;
   assign scl_fall  = ~scl_s & scl_prev;
   assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
   assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

   // pin zero caught once after reset release, later it carries hv
   always_ff @(posedge clk) begin
      if (rst) begin
         a0_taken   <= 1'b0;
         a0_latched <= 1'b1;
      end else if (!a0_taken) begin
         a0_taken   <= 1'b1;
         a0_latched <= addr_pin_zero;
      end
   end

   // own address by variant; absent pins read as one
   always_comb begin
      case (VARIANT)
         VARIANT_ONE_PIN: own_addr = {ADDR_FIXED, 1'b1, 1'b1, a0_latched};
         VARIANT_TWO_PIN: own_addr = {ADDR_FIXED, 1'b1, addr_pin_one, a0_latched};
         VARIANT_THREE:   own_addr = {ADDR_FIXED, addr_pin_two, addr_pin_one, a0_latched};
         default:         own_addr = {ADDR_FIXED, 3'h7};
      endcase
   end

   // repeated start collision: clock low again while data still high
   always_ff @(posedge clk) begin
      if (rst) begin
         rs_pending <= 1'b0;
         collision  <= 1'b0;
      end else begin
         collision <= 1'b0;
         if (state == ST_WAIT && scl_rise && !sda_s && !is_read) rs_pending <= 1'b1;
         if (start_det || stop_det) rs_pending <= 1'b0;
         // failed repeated start: clock falls while data is still high
         if (rs_pending && scl_fall && sda_s) begin
            collision  <= 1'b1;
            rs_pending <= 1'b0;
         end
      end
   end

   // hv marker sticky over a whole command sequence
   always_ff @(posedge clk) begin
      if (rst || stop_det) hv_seen <= 1'b0;
      else if (high_voltage_cmd_input) hv_seen <= 1'b1;
   end

   // hs mode on after master code, off at stop
   always_ff @(posedge clk) begin
      if (rst || stop_det) hs_mode <= 1'b0;
      else if (state == ST_ADDR && scl_fall && bit_cnt == BIT_COUNT_ACK
               && shreg[7:3] == HS_CODE_TOP) hs_mode <= 1'b1;
   end

   // bit engine: address, ack slot, bytes in or out
   always_ff @(posedge clk) begin
      if (rst || stop_det || collision) begin
         state      <= ST_IDLE;
         bit_cnt    <= BIT_COUNT_RST;
         ack_drive  <= 1'b0;
         tx_drive   <= 1'b0;
         is_read    <= 1'b0;
         first_byte <= 1'b0;
         shreg      <= 8'h00;
      end else if (start_det) begin
         state      <= ST_ADDR;
         bit_cnt    <= BIT_COUNT_RST;
         ack_drive  <= 1'b0;
         tx_drive   <= 1'b0;
         is_read    <= 1'b0;
         first_byte <= 1'b1;
      end else begin
         case (state)
            ST_ADDR, ST_CMD, ST_DATA: begin
               if (scl_rise) begin
                  shreg   <= {shreg[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BIT_COUNT_ACK) begin
                  bit_cnt <= BIT_COUNT_RST;
                  if (state == ST_ADDR) begin
                     // seven-bit match; hs code and 10-bit headers fall to nack
                     if (shreg[7:1] == own_addr ||
                         (shreg[7:1] == GENERAL_CALL && !shreg[0]
                          && tcon_word[GCA_BIT_POS])) begin
                        ack_drive <= 1'b1;
                        is_read   <= shreg[0] && shreg[7:1] != GENERAL_CALL;
                        state     <= ST_ACK;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end else if (!buf_in_ready) begin
                     state <= ST_WAIT;                       // no room: nack, drop
                  end else if (state == ST_CMD && !cmd_valid_in) begin
                     state <= ST_WAIT;
                  end else begin
                     ack_drive <= 1'b1;
                     state     <= ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               // release after the ninth clock low edge
               if (scl_fall) begin
                  ack_drive <= 1'b0;
                  if (is_read) begin
                     shreg    <= rd_data;
                     tx_drive <= ~rd_data[7];
                     bit_cnt  <= 4'h1;
                     state    <= ST_READ;
                  end else begin
                     state      <= first_byte ? ST_CMD : ST_DATA;
                     first_byte <= 1'b0;
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  if (bit_cnt == BIT_COUNT_ACK) begin
                     tx_drive <= 1'b0;
                     bit_cnt  <= BIT_COUNT_RST;
                     state    <= ST_WAIT;
                  end else begin
                     shreg    <= {shreg[6:0], 1'b0};
                     tx_drive <= ~shreg[6];
                     bit_cnt  <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_WAIT: begin
               // master ack after a read byte continues the read
               if (is_read && scl_rise) begin
                  if (!sda_s) state <= ST_ACK;
                  else        is_read <= 1'b0;
               end
            end
            ST_IDLE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
      end
   end

   // open-drain data: enable only, clock is never driven
   assign sda_o       = 1'b0;
   assign sda_oe      = ack_drive | tx_drive;
   assign frame_abort = stop_det | start_det | collision;
   assign busy        = state != ST_IDLE && state != ST_WAIT;

   // byte pushed on the ack decision for cmd and data bytes
   assign buf_in_valid = (state == ST_CMD || (state == ST_DATA)) && scl_fall
                         && bit_cnt == BIT_COUNT_ACK && !start_det && !stop_det
                         && !collision && (state != ST_CMD || cmd_valid_in);
   assign buf_in       = '{first: state == ST_CMD, hv: hv_seen | high_voltage_cmd_input,
                           data: shreg};
   assign buf_in_ready = count != 2'(BUF_DEPTH);

   // two-entry buffer; a full buffer turns into nack upstream
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (buf_in_valid && buf_in_ready) begin
            buf_mem[wr_ptr] <= buf_in;
            wr_ptr          <= ~wr_ptr;
         end
         if (word_valid && word_ready) rd_ptr <= ~rd_ptr;
         count <= count + 2'(buf_in_valid && buf_in_ready) - 2'(word_valid && word_ready);
      end
   end

   assign word_valid = count != 2'h0;
   assign word_out   = buf_mem[rd_ptr];

   // checks
   property p_ack_on_ninth;
      @(posedge clk) disable iff (rst)
      $rose(ack_drive) |-> $past(scl_fall) && $past(bit_cnt) == BIT_COUNT_ACK;
   endproperty
   a_ack_on_ninth: assert property (p_ack_on_ninth) else $error("ack not after 8 bits");

   property p_stop_idle;
      @(posedge clk) disable iff (rst)
      stop_det |=> state == ST_IDLE && !sda_oe;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop did not reset");

   property p_start_addr;
      @(posedge clk) disable iff (rst)
      start_det && !stop_det && !collision |=> state == ST_ADDR && bit_cnt == 4'h0;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start not restarting");

   property p_hs_off;
      @(posedge clk) disable iff (rst)
      stop_det |=> !hs_mode;
   endproperty
   a_hs_off: assert property (p_hs_off) else $error("hs mode kept over stop");

   property p_hs_nack;
      @(posedge clk) disable iff (rst)
      $rose(hs_mode) |-> !ack_drive;
   endproperty
   a_hs_nack: assert property (p_hs_nack) else $error("hs code acked");

   property p_gc_gate;
      @(posedge clk) disable iff (rst)
      $rose(ack_drive) && $past(state) == ST_ADDR && $past(shreg[7:1]) == GENERAL_CALL
      |-> $past(tcon_word[GCA_BIT_POS]);
   endproperty
   a_gc_gate: assert property (p_gc_gate) else $error("general call acked disabled");

   property p_bad_cmd_nack;
      @(posedge clk) disable iff (rst)
      state == ST_CMD && scl_fall && bit_cnt == BIT_COUNT_ACK && !cmd_valid_in
      && !start_det && !stop_det && !collision |=> !ack_drive ##1 !ack_drive;
   endproperty
   a_bad_cmd_nack: assert property (p_bad_cmd_nack) else $error("invalid command acked");

   property p_collision;
      @(posedge clk) disable iff (rst)
      collision |=> state == ST_IDLE;
   endproperty
   a_collision: assert property (p_collision) else $error("collision not reset");

   property p_release;
      @(posedge clk) disable iff (rst)
      state == ST_IDLE || state == ST_ADDR |-> !tx_drive;
   endproperty
   a_release: assert property (p_release) else $error("data driven outside read");

   c_ack:  cover property (@(posedge clk) disable iff (rst) $rose(ack_drive));
   c_read: cover property (@(posedge clk) disable iff (rst) state == ST_READ);
   c_hs:   cover property (@(posedge clk) disable iff (rst) $rose(hs_mode));
   c_full: cover property (@(posedge clk) disable iff (rst) count == 2'h2);
endmodule : ips_slave
`default_nettype wire

// file: test/ips_master_model.sv
`default_nettype none
// bus master model: owns scl, pulls data low only through m_low
module ips_master_model #(
   parameter int HALF = 32                  // scl half period in ns
)(
   output var logic scl,                    // serial clock
   output var logic m_low,                  // master pulls data low
   input  wire logic sda                    // resolved data wire
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idles with clock high and data released
   initial begin
      scl   = 1'b1;
      m_low = 1'b0;
   end
   // data moves only while scl is low; ex stretches low time for slave turnaround
   task automatic bit_io(input logic b, input int ex, output logic s);
      #(HALF / 2);
      m_low = ~b;
      #(HALF / 2 + ex);
      scl = 1'b1;
      #(HALF - 1);
      s = sda;
      #1;
      scl = 1'b0;
   endtask : bit_io
   // data falls while clock high
   task automatic start();
      m_low = 1'b1;
      #(HALF);
      scl = 1'b0;
   endtask : start
   // release data, raise clock, then start again without a stop
   task automatic rstart();
      #(2 * HALF);
      m_low = 1'b0;
      #(HALF);
      scl = 1'b1;
      #(HALF);
      start();
   endtask : rstart
   task automatic stop();
      #(2 * HALF);
      m_low = 1'b1;
      #(HALF);
      scl = 1'b1;
      #(HALF);
      m_low = 1'b0;
      #(2 * HALF);
   endtask : stop
   // clock stands low between bytes so a held ack has dropped
   task automatic wr(input logic [7:0] d, output logic ack);
      logic s;
      #(2 * HALF);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], 0, s);
      end
      bit_io(1'b1, HALF, s);
      ack = ~s;
   endtask : wr
   task automatic rd(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, HALF, s);
         d[i] = s;
      end
      bit_io(nack, HALF, s);
   endtask : rd
endmodule : ips_master_model
`default_nettype wire

// file: test/ips_slave_tb.sv
`default_nettype none
`define CHK(got, exp) begin \
   n_checks++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("mismatch at %0t got %h exp %h", $time, got, exp); \
   end \
end
module ips_slave_tb
   import ips_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 40000;            // cycles, some twenty times the planned run
   logic       clk, rst, scl, m_low, sda, sda_o, sda_oe, ack, abort_seen;
   logic       addr_pin_zero, addr_pin_one, addr_pin_two, high_voltage_cmd_input;
   logic       cmd_valid_in, word_valid, word_ready, frame_abort, hs_mode, busy;
   logic [8:0] tcon_word;
   logic [7:0] rd_data, d0, d1, got;
   logic [6:0] own;
   logic [6:0] t_addr[5];
   logic       t_gca[5], t_ack[5];
   ips_word_s  word_out;
   int         miscompares, n_checks, cyc, seed;

   // open-drain wire with pull-up: low while either party pulls
   assign sda = ~(m_low | (sda_oe & ~sda_o));

   ips_slave i_ips_slave (
      .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .addr_pin_zero(addr_pin_zero), .addr_pin_one(addr_pin_one),
      .addr_pin_two(addr_pin_two), .high_voltage_cmd_input(high_voltage_cmd_input),
      .tcon_word(tcon_word), .cmd_valid_in(cmd_valid_in), .rd_data(rd_data),
      .word_valid(word_valid), .word_ready(word_ready), .word_out(word_out),
      .frame_abort(frame_abort), .hs_mode(hs_mode), .busy(busy));
   ips_master_model #(.HALF(32)) i_ips_master_model (.scl(scl), .m_low(m_low), .sda(sda));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // one-cycle abort pulse is caught here; hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (frame_abort === 1'b1) abort_seen <= 1'b1;
      if (cyc == LIMIT) begin
         miscompares++;
         give_verdict();
      end
   end

   function automatic logic [6:0] own_addr(logic p2, logic p1, logic p0);
      return {ADDR_FIXED, p2, p1, p0};
   endfunction : own_addr
   task automatic head(input logic [7:0] b, input logic exp);
      i_ips_master_model.start();
      i_ips_master_model.wr(b, ack);
      `CHK(ack, exp)
   endtask : head
   task automatic fin();
      i_ips_master_model.stop();
      repeat (10) @(negedge clk);
   endtask : fin
   // single-cycle ready takes exactly one word
   task automatic pop();
      @(negedge clk);
      word_ready = 1'b1;
      @(negedge clk);
      word_ready = 1'b0;
   endtask : pop
   task automatic give_verdict();
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      seed = $urandom(32'h81ebd9f7);
      rst = 1'b1;
      word_ready = 1'b0;
      high_voltage_cmd_input = 1'b0;
      cmd_valid_in = 1'b1;
      tcon_word = 9'h1FF;
      abort_seen = 1'b0;
      {addr_pin_two, addr_pin_one, addr_pin_zero} = 3'($urandom);
      rd_data = 8'($urandom);
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      own = own_addr(addr_pin_two, addr_pin_one, addr_pin_zero);
      repeat (8) @(negedge clk);
      `CHK({sda_oe, word_valid, hs_mode, busy}, 4'h0)
      // pin zero now carries the hv level; matching must keep the latched value
      addr_pin_zero = ~addr_pin_zero;
      high_voltage_cmd_input = 1'b1;
      head({own, 1'b0}, 1'b1);
      i_ips_master_model.wr(d0, ack);
      `CHK(ack, 1'b1)
      i_ips_master_model.wr(d1, ack);
      `CHK(busy, 1'b1)
      i_ips_master_model.wr(8'hA5, ack);
      `CHK(ack, 1'b0)
      @(negedge clk);
      abort_seen = 1'b0;
      fin();
      `CHK({abort_seen, busy}, 2'b10)
      high_voltage_cmd_input = 1'b0;
      `CHK(word_out, ips_word_s'({1'b1, 1'b1, d0}))
      pop();
      `CHK(word_out, ips_word_s'({1'b0, 1'b1, d1}))
      pop();
      `CHK(word_valid, 1'b0)
      // read back, no clock stretch available to the slave
      head({own, 1'b1}, 1'b1);
      i_ips_master_model.rd(1'b1, got);
      `CHK(got, rd_data)
      fin();
      // refusals: prefix, ten-bit header, general call gated off (acked once enabled), current pin zero
      t_addr = '{own ^ 7'h40, {5'h1E, own[1:0]}, GENERAL_CALL, GENERAL_CALL,
                 own_addr(addr_pin_two, addr_pin_one, addr_pin_zero)};
      t_gca = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      t_ack = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         tcon_word = {t_gca[i], 8'($urandom)};
         head({t_addr[i], 1'b0}, t_ack[i]);
         fin();
      end
      // bad command refused, later bytes ignored, repeated start recovers
      @(negedge clk);
      cmd_valid_in = 1'b0;
      head({own, 1'b0}, 1'b1);
      i_ips_master_model.wr(d0, ack);
      `CHK(ack, 1'b0)
      i_ips_master_model.wr(d1, ack);
      `CHK(ack, 1'b0)
      @(negedge clk);
      cmd_valid_in = 1'b1;
      i_ips_master_model.rstart();
      i_ips_master_model.wr({own, 1'b0}, ack);
      `CHK(ack, 1'b1)
      i_ips_master_model.wr(d1, ack);
      `CHK(ack, 1'b1)
      fin();
      `CHK(word_out, ips_word_s'({1'b1, 1'b0, d1}))
      pop();
      `CHK(word_valid, 1'b0)
      // high-speed code: refused, mode entered, left on stop
      head({HS_CODE_TOP, 3'($urandom)}, 1'b0);
      `CHK(hs_mode, 1'b1)
      // the address byte after the master code follows a repeated start
      i_ips_master_model.rstart();
      i_ips_master_model.wr({own, 1'b0}, ack);
      `CHK(ack, 1'b1)
      fin();
      `CHK(hs_mode, 1'b0)
      give_verdict();
   end
endmodule : ips_slave_tb
`default_nettype wire
